// >>> include/mdc_pkg.sv
`default_nettype none
package mdc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [7:0] ADDR_DUTY = 8'h30;
    localparam logic [7:0] ADDR_RX_NEG = 8'h31;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h32;
    localparam logic [7:0] ADDR_MU_CTRL = 8'h33;
    localparam logic [7:0] ADDR_RB_LOW = 8'h39;
    localparam logic [7:0] ADDR_RB_HIGH = 8'h3A;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_RX_NEG = 8'h00;
    localparam logic [7:0] RST_RX_CTRL = 8'h00;
    localparam logic [7:0] RST_MU_CTRL = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [8:0] RST_DELAY = 9'h000;
    localparam logic [4:0] RST_PHASE = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DUTY_DCC_BIT = 7;
    localparam int RXN_TRIM_LSB = 4;
    localparam int RXC_ON_BIT = 7;
    localparam int RXC_PPOL_BIT = 5;
    localparam int RXC_PTRIM_LSB = 1;
    localparam int RXC_NPOL_BIT = 0;
    localparam int MU_GATE_BIT = 7;
    localparam int MU_SLOPE_BIT = 6;
    localparam int MU_MODE_LSB = 4;
    localparam int MU_SNAP_BIT = 3;
    localparam int MU_GAIN_LSB = 1;
    localparam int DELAY_CTRL_ENABLE_BIT = 0;
    localparam int RB_DELAY_LSB_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // Widths and limits
    localparam int TRIM_W = 4;
    localparam int DELAY_W = 9;
    localparam int PHASE_W = 5;
    localparam logic [8:0] DELAY_MAX = 9'h1AF;
    localparam logic [8:0] DELAY_START = 9'h0D8;
    localparam logic [4:0] PHASE_MAX = 5'h10;

    typedef enum logic [1:0] {
        MDC_MODE_SEARCH_TRACK = 2'h0,
        MDC_MODE_TRACK = 2'h1,
        MDC_MODE_SEARCH = 2'h2,
        MDC_MODE_INVALID = 2'h3
    } mdc_mode_t;

    typedef enum logic [1:0] {
        MDC_GAIN_SLOW = 2'h0,
        MDC_GAIN_NOMINAL = 2'h1,
        MDC_GAIN_FAST = 2'h2,
        MDC_GAIN_INVALID = 2'h3
    } mdc_gain_t;

    // Configuration driven into the analog and controller logic
    typedef struct packed {
        logic dcc_enable;
        logic [TRIM_W-1:0] neg_pin_common_mode_trim;
        logic [TRIM_W-1:0] pos_pin_common_mode_trim;
        logic pos_trim_polarity;
        logic neg_trim_polarity;
        logic clock_receiver_on;
        logic delay_ctrl_clock_gate;
        logic target_slope_positive;
        mdc_mode_t mode;
        mdc_gain_t gain;
        logic delay_ctrl_enable;
    } mdc_cfg_t;

    // Locked values reported by the delay controller
    typedef struct packed {
        logic [DELAY_W-1:0] delay_line_value;
        logic [PHASE_W-1:0] target_phase_value;
    } mdc_lock_t;

endpackage : mdc_pkg
`default_nettype wire

// >>> src/mdc_regs.sv
// Overview of operation
// - Duty-cycle register bit 7 set to 1 turns on duty-cycle correction.
// - First receiver register bits 7:4 set negative pin common-mode trim.
// - Second receiver register bits 4:1 set positive pin common-mode trim.
// - Second receiver bit 5 sets positive trim sign, 0 negative.
// - Second receiver bit 0 sets negative trim sign, 0 negative.
// - Receiver enable bit 7 resets to 0; 1 enables the receiver.
// - Controller control bit 7 gates controller clock; 1 stops it.
// - Bit 6 gives target phase slope compared after measurement.
// - Bits 5:4 pick search-track, track, search, or invalid mode.
// - Rising transition of bit 3 captures locked delay and phase.
// - Bits 2:1 set tracking rate slowest, nominal, fastest.
// - Bit 0 turns controller on (auto) or off (manual delay).
// - Delay value is nine bits, at most 431, start near 216.
// - Target phase field is five bits, at most 16.
`default_nettype none
module mdc_regs (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire mdc_pkg::mdc_lock_t lock_in,
    output mdc_pkg::mdc_cfg_t cfg_out,
    output mdc_pkg::mdc_lock_t snap_out
);
    import mdc_pkg::*;

    logic [7:0] duty_reg;
    logic [7:0] rx_neg_reg;
    logic [7:0] rx_ctrl_reg;
    logic [7:0] mu_ctrl_reg;
    mdc_lock_t lock_meta;
    mdc_lock_t lock_sync;
    mdc_lock_t snap;
    logic snap_fire;
    logic [7:0] next_rdata;
    logic sel_duty;
    logic sel_rx_neg;
    logic sel_rx_ctrl;
    logic sel_mu_ctrl;
    logic wr_duty;
    logic wr_rx_neg;
    logic wr_rx_ctrl;
    logic wr_mu_ctrl;
    mdc_lock_t lock_hist;
    logic lock_settled;
    logic snap_pending;
    logic snap_take;
    mdc_cfg_t next_cfg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode; readback addresses take no writes
    always_comb begin
        sel_duty = 1'b0;
        sel_rx_neg = 1'b0;
        sel_rx_ctrl = 1'b0;
        sel_mu_ctrl = 1'b0;
        case (cfg_addr)
            ADDR_DUTY: begin
                sel_duty = 1'b1;
            end
            ADDR_RX_NEG: begin
                sel_rx_neg = 1'b1;
            end
            ADDR_RX_CTRL: begin
                sel_rx_ctrl = 1'b1;
            end
            ADDR_MU_CTRL: begin
                sel_mu_ctrl = 1'b1;
            end
            default: begin
                sel_duty = 1'b0;
            end
        endcase
    end

    assign wr_duty = cfg_wr && sel_duty;
    assign wr_rx_neg = cfg_wr && sel_rx_neg;
    assign wr_rx_ctrl = cfg_wr && sel_rx_ctrl;
    assign wr_mu_ctrl = cfg_wr && sel_mu_ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are plain storage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            duty_reg <= RST_DUTY;
        end else if (wr_duty) begin
            duty_reg <= cfg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_neg_reg <= RST_RX_NEG;
        end else if (wr_rx_neg) begin
            rx_neg_reg <= cfg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_ctrl_reg <= RST_RX_CTRL;
        end else if (wr_rx_ctrl) begin
            rx_ctrl_reg <= cfg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mu_ctrl_reg <= RST_MU_CTRL;
        end else if (wr_mu_ctrl) begin
            mu_ctrl_reg <= cfg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Snapshot trigger: only a written 1 over a stored 0 fires
    assign snap_fire = wr_mu_ctrl && cfg_wdata[MU_SNAP_BIT]
        && !mu_ctrl_reg[MU_SNAP_BIT];

    // Locked values come from the DAC clock side
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_meta <= '0;
            lock_sync <= '0;
        end else begin
            lock_meta <= lock_in;
            lock_sync <= lock_meta;
        end
    end

    // Third stage compares against the synchronised word only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_hist <= '0;
        end else begin
            lock_hist <= lock_sync;
        end
    end

    // A word caught mid-change would mix old and new bits
    assign lock_settled = lock_sync == lock_hist;
    assign snap_take = (snap_fire || snap_pending) && lock_settled;

    // Trigger waits for a settled word; a fresh trigger wins over the clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap_pending <= 1'b0;
        end else if (snap_fire && !lock_settled) begin
            snap_pending <= 1'b1;
        end else if (lock_settled) begin
            snap_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap.delay_line_value <= RST_DELAY;
            snap.target_phase_value <= RST_PHASE;
        end else if (snap_take) begin
            snap <= lock_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field unpacking for the controller and the clock receiver
    always_comb begin
        next_cfg = '0;
        next_cfg.dcc_enable = duty_reg[DUTY_DCC_BIT];
        next_cfg.neg_pin_common_mode_trim =
            rx_neg_reg[RXN_TRIM_LSB +: TRIM_W];
        next_cfg.pos_pin_common_mode_trim =
            rx_ctrl_reg[RXC_PTRIM_LSB +: TRIM_W];
        next_cfg.pos_trim_polarity = rx_ctrl_reg[RXC_PPOL_BIT];
        next_cfg.neg_trim_polarity = rx_ctrl_reg[RXC_NPOL_BIT];
        next_cfg.clock_receiver_on = rx_ctrl_reg[RXC_ON_BIT];
        next_cfg.delay_ctrl_clock_gate = mu_ctrl_reg[MU_GATE_BIT];
        next_cfg.target_slope_positive = mu_ctrl_reg[MU_SLOPE_BIT];
        next_cfg.mode = mdc_mode_t'(mu_ctrl_reg[MU_MODE_LSB +: 2]);
        next_cfg.gain = mdc_gain_t'(mu_ctrl_reg[MU_GAIN_LSB +: 2]);
        next_cfg.delay_ctrl_enable = mu_ctrl_reg[DELAY_CTRL_ENABLE_BIT];
    end

    // Outputs to the controller and the clock receiver
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= next_cfg;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap_out <= '0;
        end else begin
            snap_out <= snap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = RST_RDATA;
        case (cfg_addr)
            ADDR_DUTY: next_rdata = duty_reg;
            ADDR_RX_NEG: next_rdata = rx_neg_reg;
            ADDR_RX_CTRL: next_rdata = rx_ctrl_reg;
            ADDR_MU_CTRL: next_rdata = mu_ctrl_reg;
            ADDR_RB_LOW: begin
                next_rdata[RB_DELAY_LSB_BIT] = snap.delay_line_value[0];
                next_rdata[PHASE_W-1:0] = snap.target_phase_value;
            end
            ADDR_RB_HIGH: next_rdata = snap.delay_line_value[DELAY_W-1:1];
            default: next_rdata = RST_RDATA;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= RST_RDATA;
        end else if (cfg_rd) begin
            cfg_rdata <= next_rdata;
        end
    end

    // Read strobe echo, one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
        end
    end

endmodule : mdc_regs
`default_nettype wire

// >>> dv/mdc_regs_chk.sv
`default_nettype none
module mdc_regs_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire mdc_pkg::mdc_lock_t lock_in,
    input wire mdc_pkg::mdc_cfg_t cfg_out,
    input wire mdc_pkg::mdc_lock_t snap_out
);
    import mdc_pkg::*;
    logic snap_q;
    wire mu_wr = cfg_wr && cfg_addr == ADDR_MU_CTRL;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) snap_q <= 1'b0;
        else if (mu_wr) snap_q <= cfg_wdata[MU_SNAP_BIT];
    end
    chk_dcc_on: assert property (cfg_wr && cfg_addr == ADDR_DUTY |->
        ##2 cfg_out[18] == $past(cfg_wdata[7], 2)) else $error("dcc");
    chk_neg_trim: assert property (
        cfg_wr && cfg_addr == ADDR_RX_NEG |->
        ##2 cfg_out[17:14] == $past(cfg_wdata[7:4], 2)) else $error("neg");
    chk_rx_fields: assert property (
        cfg_wr && cfg_addr == ADDR_RX_CTRL |-> ##2 cfg_out[13:7] ==
        $past({cfg_wdata[4:1], cfg_wdata[5], cfg_wdata[0], cfg_wdata[7]}, 2))
        else $error("rx");
    chk_mu_fields: assert property (
        mu_wr |-> ##2 cfg_out[6:0] ==
        $past({cfg_wdata[7:4], cfg_wdata[2:0]}, 2)) else $error("mu");
    chk_rx_off: assert property ($rose(nrst) |-> !cfg_out[7])
        else $error("rx on");
    chk_rb_low: assert property (
        cfg_rd && cfg_addr == ADDR_RB_LOW |=>
        cfg_rdata == {snap_out[5], 2'b00, snap_out[4:0]}) else $error("low");
    chk_rb_high: assert property (
        cfg_rd && cfg_addr == ADDR_RB_HIGH |=>
        cfg_rdata == snap_out[13:6]) else $error("high");
    chk_snap_cap: assert property (
        $stable(lock_in) [*3] ##0 mu_wr && cfg_wdata[3] && !snap_q |->
        ##2 snap_out == $past(lock_in, 2)) else $error("snap");
    cov_snap: cover property (mu_wr && cfg_wdata[3] && !snap_q);
    cov_unmapped: cover property (cfg_rd && cfg_addr == 8'h34);
    cov_rx_on: cover property (cfg_out[7]);
endmodule : mdc_regs_chk
bind mdc_regs mdc_regs_chk mdc_regs_chk_inst (.core_clk, .nrst, .cfg_addr,
    .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .cfg_rvalid, .lock_in,
    .cfg_out, .snap_out);
`default_nettype wire

// >>> dv/tb_mdc_regs.sv
`default_nettype none
module tb_mdc_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import mdc_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic cfg_rvalid;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    mdc_lock_t lock_in = '0, snap_out;
    mdc_cfg_t cfg_out;
    int err_total = 0, n_tests = 0;
    mdc_regs mdc_regs_inst (.core_clk, .nrst, .cfg_addr, .cfg_wdata, .cfg_wr,
        .cfg_rd, .cfg_rdata, .cfg_rvalid, .lock_in, .cfg_out, .snap_out);
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(input logic [18:0] s, input logic [18:0] e);
        n_tests++;
        if (s !== e) err_total++;
        if (s !== e) $display("mismatch %0t seen=%h exp=%h", $time, s, e);
    endtask : chk
    // One register access; reads are checked against d
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {cfg_wr, cfg_rd} <= {w, !w};
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge core_clk);
        {cfg_wr, cfg_rd} <= 2'b00;
        #1;
        if (!w) chk({cfg_rvalid, cfg_rdata}, {1'b1, d});
    endtask : acc
    task automatic conclude;
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic t_fields;
        chk(cfg_out, '0);
        acc(1'b1, ADDR_DUTY, 8'h80);
        acc(1'b1, ADDR_RX_NEG, 8'hA5);
        acc(1'b1, ADDR_RX_CTRL, 8'h9F);
        acc(1'b1, ADDR_MU_CTRL, 8'hD3);
        acc(1'b0, ADDR_RX_NEG, 8'hA5);
        acc(1'b0, ADDR_DUTY, 8'h80);
        chk(cfg_out, {1'b1, 4'hA, 4'hF, 5'h0F, 5'h0B});
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, ADDR_MU_CTRL,
                {2'b01, k[1:0], 1'b0, k[1], 2'b01});
            acc(1'b0, 8'h34, 8'h00);
            chk(cfg_out[6:0], {2'b01, k[1:0], k[1], 2'b01});
        end
    endtask : t_fields
    task automatic t_snap;
        @(posedge core_clk) lock_in <= {9'h1AF, 5'h0E};
        repeat (4) @(posedge core_clk);
        acc(1'b1, ADDR_MU_CTRL, 8'h08);
        acc(1'b0, ADDR_RB_LOW, 8'h8E);
        acc(1'b0, ADDR_RB_HIGH, 8'hD7);
        @(posedge core_clk) lock_in <= {9'h0D8, 5'h10};
        repeat (4) @(posedge core_clk);
        acc(1'b1, ADDR_MU_CTRL, 8'h08);
        acc(1'b1, ADDR_MU_CTRL, 8'h00);
        chk(snap_out, {9'h1AF, 5'h0E});
        acc(1'b1, ADDR_MU_CTRL, 8'h08);
        acc(1'b0, ADDR_RB_LOW, 8'h10);
        acc(1'b0, ADDR_RB_HIGH, 8'h6C);
    endtask : t_snap
    // Mid-run reset returns registers and outputs to zero
    task automatic t_reset;
        @(posedge core_clk) nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk(cfg_out, '0);
        chk(snap_out, '0);
        acc(1'b0, ADDR_RX_CTRL, 8'h00);
        acc(1'b0, ADDR_RB_HIGH, 8'h00);
    endtask : t_reset
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        t_fields;
        t_snap;
        t_reset;
        conclude;
    end
    initial begin
        #50000 err_total++;
        conclude;
    end
endmodule : tb_mdc_regs
`default_nettype wire
